// file: hdl/vitpe_cfg.svh
// Constants for the vectored interrupt, timer and port event block.
// Assumes a 125 MHz aclk and an AXI4-Lite register port of 32-bit words.
`ifndef VITPE_CFG_SVH
`define VITPE_CFG_SVH

`define VITPE_CLK_HZ 125000000
`define VITPE_TICK_HZ 1000000
`define VITPE_TICK_DIV (`VITPE_CLK_HZ / `VITPE_TICK_HZ)
`define VITPE_TAP_FAST 6
`define VITPE_TAP_SLOW 9
`define VITPE_NUM_IRQ 11
`define VITPE_RESET_PC 14'h0000

`define VITPE_ADDR_TMR_LO 8'h00
`define VITPE_ADDR_TMR_HI 8'h04
`define VITPE_ADDR_IRQ_STAT 8'h08
`define VITPE_ADDR_IRQ_MASK 8'h0C
`define VITPE_ADDR_IRQ_VEC 8'h10
`define VITPE_ADDR_GP_CFG 8'h14
`define VITPE_ADDR_GP_EN0 8'h18
`define VITPE_ADDR_GP_EN1 8'h1C
`define VITPE_ADDR_GP_EN2 8'h20
`define VITPE_ADDR_GP_EN3 8'h24
`define VITPE_ADDR_SK_DATA 8'h28
`define VITPE_ADDR_SK_EN 8'h2C
`define VITPE_ADDR_SK_POL 8'h30
`define VITPE_ADDR_SK_ISINK0 8'h40
`define VITPE_ADDR_GP_DATA0 8'h60
`define VITPE_ADDR_GP_DATA3 8'h6C

`define VITPE_BIT_TMR_FAST 0
`define VITPE_BIT_TMR_SLOW 1
`define VITPE_BIT_EP0 2
`define VITPE_BIT_HUB 7
`define VITPE_BIT_SINK 8
`define VITPE_BIT_GPIO 9
`define VITPE_BIT_SER 10

`define VITPE_SK_DATA_RST 8'hFF

`endif

// file: hdl/vitpe_pkg.sv
// Types for the vectored interrupt, timer and port event block.
// Assumes the constants header is compiled alongside.
package vitpe_pkg;
  typedef enum logic [1:0] {
    VITPE_GP_PULLUP_IN,
    VITPE_GP_OPEN_DRAIN,
    VITPE_GP_PUSH_PULL,
    VITPE_GP_RESERVED
  } vitpe_gp_mode_t;

  typedef struct packed {
    vitpe_gp_mode_t mode;
    logic rising;
  } vitpe_gp_cfg_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } vitpe_pin_drive_t;
endpackage

// file: hdl/vitpe_top.sv
// Vectored interrupt sources, 12-bit microsecond timer, port pin events and
// the programmable current-sink port, with an AXI4-Lite register slave.
// Assumes pins are asynchronous to aclk; USB and serial events are aclk pulses.
// Functional notes
// - Eleven maskable vectored interrupt sources
// - Twelve-bit counter advancing each microsecond
// - Timer interrupt on bit 6/9 rising
// - Low byte read captures upper nibble
// - Upper nibble read returns held copy
// - All port pins share one vector
// - Per-pin enable for port pin events
// - Per-pin enable on sink port
// - Per-pin edge polarity on sink port
// - Port edge polarity set per port
// - Fire on rising or falling edge
// - Writing one releases sink, pull-up high
// - Writing zero sinks the programmed current
// - Per-pin sixteen-level sink current setting
// - Endpoint events raise endpoint interrupts
// - Port modes: pull-up, open-drain, push-pull
// - Reset clears all but sink data (set to all ones), start address zero; the pin synchroniser chains have no reset
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`include "vitpe_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module vitpe_top #(
  parameter int TICK_DIV = `VITPE_TICK_DIV,
  parameter int GP3_WIDTH = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] gp_pins_in,
  output vitpe_pkg::vitpe_pin_drive_t [3:0] gp_drive,
  output logic [3:0] gp_pullup_en,
  input wire logic [7:0] sink_port_pins_in,
  output logic [7:0] sink_port_pullup_en,
  output logic [7:0] sink_port_sink_en,
  output logic [31:0] sink_port_isink,
  input wire logic [4:0] usb_ep_event,
  input wire logic usb_hub_event,
  input wire logic serial_event,
  output logic irq,
  output logic [3:0] irq_vector,
  output logic [13:0] reset_pc
);
  if (TICK_DIV < 1 || GP3_WIDTH < 1 || GP3_WIDTH > 8)
  begin : g_bad_param
    $error("vitpe_top: unsupported parameter value");
  end

  localparam logic [7:0] GP3_MASK = 8'(((1 << GP3_WIDTH) - 1));

  // AXI4-Lite slave: one write and one read outstanding
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic rd_fire;
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_hold_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_hold_q <= 1'b0;
    end
  end

  logic wr_ok, wr_err;
  logic [7:0] wr_byte;
  assign wr_byte = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
  assign wr_err = awaddr_q[1:0] != 2'h0 || awaddr_q > `VITPE_ADDR_GP_DATA3
    || (awaddr_q > `VITPE_ADDR_SK_POL && awaddr_q < `VITPE_ADDR_SK_ISINK0);
  assign wr_ok = wr_fire && wstrb_q[0] && !wr_err;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? 2'h2 : 2'h0;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Microsecond tick from aclk divider
  logic [$clog2(TICK_DIV + 1)-1:0] div_q;
  logic tick;
  assign tick = (div_q == ($bits(div_q))'(TICK_DIV - 1));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= '0;
    else if (tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  logic [11:0] tmr_q;
  logic [3:0] tmr_hold_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tmr_q <= 12'h000;
    else if (tick)
      tmr_q <= tmr_q + 12'h001;
  end

  logic rd_lo;
  assign rd_lo = rd_fire && s_axi_araddr == `VITPE_ADDR_TMR_LO;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tmr_hold_q <= 4'h0;
    else if (rd_lo)
      tmr_hold_q <= tmr_q[11:8];
  end

  logic tap_fast_ev, tap_slow_ev;
  // Tap bit rises when all lower bits roll over on a tick
  assign tap_fast_ev = tick && tmr_q[`VITPE_TAP_FAST:0] == 7'h3F;
  assign tap_slow_ev = tick && tmr_q[`VITPE_TAP_SLOW:0] == 10'h1FF;

  // Pin synchronisers and edge detection
  logic [31:0] gp_s1_q, gp_s2_q, gp_s3_q;
  logic [7:0] sk_s1_q, sk_s2_q, sk_s3_q;
  // No reset: the chain follows the pins, so no false edge after reset
  always_ff @(posedge aclk)
  begin
    gp_s1_q <= gp_pins_in;
    gp_s2_q <= gp_s1_q;
    gp_s3_q <= gp_s2_q;
    sk_s1_q <= sink_port_pins_in;
    sk_s2_q <= sk_s1_q;
    sk_s3_q <= sk_s2_q;
  end

  vitpe_pkg::vitpe_gp_cfg_t [3:0] gp_cfg_q;
  logic [3:0][7:0] gp_en_q;
  logic [3:0][7:0] gp_data_q;
  logic [7:0] sk_data_q, sk_en_q, sk_pol_q;
  logic [7:0][3:0] sk_isink_q;
  logic [31:0] gp_hit;
  logic [7:0] sk_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_gp
      logic rise, fall;
      assign rise = gp_s2_q[gi] && !gp_s3_q[gi];
      assign fall = !gp_s2_q[gi] && gp_s3_q[gi];
      assign gp_hit[gi] = gp_en_q[gi / 8][gi % 8] && (gp_cfg_q[gi / 8].rising ? rise : fall);
    end
    for (gi = 0; gi < 8; gi++)
    begin : g_sk
      logic rise, fall;
      assign rise = sk_s2_q[gi] && !sk_s3_q[gi];
      assign fall = !sk_s2_q[gi] && sk_s3_q[gi];
      assign sk_hit[gi] = sk_en_q[gi] && (sk_pol_q[gi] ? rise : fall);
      assign sink_port_pullup_en[gi] = sk_data_q[gi];
      assign sink_port_sink_en[gi] = !sk_data_q[gi];
      assign sink_port_isink[gi*4 +: 4] = sk_isink_q[gi];
    end
    for (gi = 0; gi < 4; gi++)
    begin : g_drv
      logic [7:0] valid_bits;
      assign valid_bits = (gi == 3) ? GP3_MASK : 8'hFF;
      assign gp_drive[gi].out = gp_data_q[gi] & valid_bits;
      assign gp_drive[gi].oe = (gp_cfg_q[gi].mode == vitpe_pkg::VITPE_GP_PUSH_PULL) ? valid_bits :
        (gp_cfg_q[gi].mode == vitpe_pkg::VITPE_GP_OPEN_DRAIN) ? (~gp_data_q[gi] & valid_bits) : 8'h00;
      assign gp_pullup_en[gi] = gp_cfg_q[gi].mode == vitpe_pkg::VITPE_GP_PULLUP_IN;
    end
  endgenerate

  // Eleven interrupt events
  logic [10:0] irq_ev;
  always_comb
  begin
    irq_ev = 11'h000;
    irq_ev[`VITPE_BIT_TMR_FAST] = tap_fast_ev;
    irq_ev[`VITPE_BIT_TMR_SLOW] = tap_slow_ev;
    irq_ev[`VITPE_BIT_EP0 +: 5] = usb_ep_event;
    irq_ev[`VITPE_BIT_HUB] = usb_hub_event;
    irq_ev[`VITPE_BIT_SINK] = |sk_hit;
    irq_ev[`VITPE_BIT_GPIO] = |gp_hit;
    irq_ev[`VITPE_BIT_SER] = serial_event;
  end

  logic [10:0] irq_stat_q, irq_mask_q;
  logic wr_stat;
  assign wr_stat = wr_ok && awaddr_q == `VITPE_ADDR_IRQ_STAT;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_q <= 11'h000;
    else
    begin
      // Set wins over a simultaneous write-one clear
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? {wdata_q[10:8] & {3{wstrb_q[1]}}, wr_byte} : 11'h000)) | irq_ev;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Lowest pending unmasked source is the vector
  always_comb
  begin
    irq_vector = 4'hF;
    for (int i = `VITPE_NUM_IRQ - 1; i >= 0; i--)
      if (irq_stat_q[i] && irq_mask_q[i])
        irq_vector = 4'(i);
  end

  // Register writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_mask_q <= 11'h000;
      gp_cfg_q <= '0;
      gp_en_q <= '0;
      gp_data_q <= '0;
      sk_data_q <= `VITPE_SK_DATA_RST;
      sk_en_q <= 8'h00;
      sk_pol_q <= 8'h00;
      sk_isink_q <= '0;
    end
    else if (wr_ok)
    begin
      unique case (awaddr_q)
        `VITPE_ADDR_IRQ_MASK:
        begin
          irq_mask_q[7:0] <= wr_byte;
          if (wstrb_q[1])
            irq_mask_q[10:8] <= wdata_q[10:8];
        end
        `VITPE_ADDR_GP_CFG:
          gp_cfg_q <= {wdata_q[11:9], wdata_q[8:6], wdata_q[5:3], wdata_q[2:0]} & 12'hFFF;
        `VITPE_ADDR_GP_EN0: gp_en_q[0] <= wr_byte;
        `VITPE_ADDR_GP_EN1: gp_en_q[1] <= wr_byte;
        `VITPE_ADDR_GP_EN2: gp_en_q[2] <= wr_byte;
        `VITPE_ADDR_GP_EN3: gp_en_q[3] <= wr_byte & GP3_MASK;
        `VITPE_ADDR_SK_DATA: sk_data_q <= wr_byte;
        `VITPE_ADDR_SK_EN: sk_en_q <= wr_byte;
        `VITPE_ADDR_SK_POL: sk_pol_q <= wr_byte;
        default:
        begin
          if (awaddr_q >= `VITPE_ADDR_SK_ISINK0 && awaddr_q <= `VITPE_ADDR_SK_ISINK0 + 8'h1C)
            sk_isink_q[awaddr_q[4:2]] <= wr_byte[3:0];
          else if (awaddr_q >= `VITPE_ADDR_GP_DATA0)
            gp_data_q[awaddr_q[3:2]] <= wr_byte;
        end
      endcase
    end
  end

  // Read path
  logic [31:0] rd_val;
  logic rd_err;
  always_comb
  begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    unique case (s_axi_araddr)
      `VITPE_ADDR_TMR_LO: rd_val = {24'h000000, tmr_q[7:0]};
      `VITPE_ADDR_TMR_HI: rd_val = {28'h0000000, tmr_hold_q};
      `VITPE_ADDR_IRQ_STAT: rd_val = {21'h000000, irq_stat_q};
      `VITPE_ADDR_IRQ_MASK: rd_val = {21'h000000, irq_mask_q};
      `VITPE_ADDR_IRQ_VEC: rd_val = {28'h0000000, irq_vector};
      `VITPE_ADDR_GP_CFG: rd_val = {20'h00000, gp_cfg_q};
      `VITPE_ADDR_GP_EN0: rd_val = {24'h000000, gp_en_q[0]};
      `VITPE_ADDR_GP_EN1: rd_val = {24'h000000, gp_en_q[1]};
      `VITPE_ADDR_GP_EN2: rd_val = {24'h000000, gp_en_q[2]};
      `VITPE_ADDR_GP_EN3: rd_val = {24'h000000, gp_en_q[3]};
      `VITPE_ADDR_SK_DATA: rd_val = {24'h000000, sk_s2_q};
      `VITPE_ADDR_SK_EN: rd_val = {24'h000000, sk_en_q};
      `VITPE_ADDR_SK_POL: rd_val = {24'h000000, sk_pol_q};
      default:
      begin
        if (s_axi_araddr >= `VITPE_ADDR_SK_ISINK0 && s_axi_araddr <= `VITPE_ADDR_SK_ISINK0 + 8'h1C
            && s_axi_araddr[1:0] == 2'h0)
          rd_val = {28'h0000000, sk_isink_q[s_axi_araddr[4:2]]};
        else if (s_axi_araddr[7:4] == 4'h6 && s_axi_araddr[1:0] == 2'h0)
          rd_val = {24'h000000, gp_s2_q[s_axi_araddr[3:2]*8 +: 8]};
        else
          rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  assign reset_pc = `VITPE_RESET_PC;
endmodule

`default_nettype wire

// file: tb/vitpe_asserts.sv
// Port-level checker for the timer and port event block.
// Assumes one aclk domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module vitpe_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] sink_port_pullup_en,
  input wire logic [7:0] sink_port_sink_en,
  input wire logic irq,
  input wire logic [3:0] irq_vector,
  input wire logic [13:0] reset_pc
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_sink_excl: assert property (sink_port_pullup_en == ~sink_port_sink_en)
    else $error("pull-up and sink both on or both off");
  a_pc_zero: assert property (reset_pc == 14'h0000)
    else $error("start address not zero");
  a_irq_vec: assert property (irq == (irq_vector != 4'hF))
    else $error("vector disagrees with interrupt line");
  a_reset_clean: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && sink_port_sink_en == 8'h00)
    else $error("state not clean after reset");
  cover property (irq);
  cover property ($fell(irq));
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// file: tb/vitpe_pin_board.sv
// Board model for the current-sink pins: pull-up unless sunk or pulled low.
// Assumes the bench drives pull_low to act as an outside driver.
`timescale 1ns/1ps
`default_nettype none
module vitpe_pin_board (
  input wire logic [7:0] sink_port_sink_en,
  input wire logic [7:0] pull_low,
  output logic [7:0] sink_port_pins_in
);
  assign sink_port_pins_in = ~(sink_port_sink_en | pull_low);
endmodule
`default_nettype wire

// file: tb/tb_vitpe_top.sv
// Self-checking bench for the timer and port event block.
// Assumes TICK_DIV of 2, so one microsecond is two aclk cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; $display("unexpected %s exp %0h got %0h", nm, e, s); end end
module tb_vitpe_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pull_low = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, usb_hub_event = 1'b0, serial_event = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, gp_pins_in = 32'h0, s_axi_rdata, sink_port_isink, rv;
  logic [3:0] s_axi_wstrb = 4'hF, gp_pullup_en, irq_vector;
  logic [4:0] usb_ep_event = 5'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic [7:0] sink_port_pins_in, sink_port_pullup_en, sink_port_sink_en;
  logic [13:0] reset_pc;
  vitpe_pkg::vitpe_pin_drive_t [3:0] gp_drive;
  int n_fail = 0, checked = 0, cyc = 0;
  vitpe_top #(.TICK_DIV(2)) u_vitpe_top (.*);
  vitpe_pin_board u_vitpe_pin_board (.*);
  always #4 aclk = ~aclk;
  task wrap_up;
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Ceiling well above the few thousand cycles the scenarios need
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    rd(a);
    `CHK(nm, e, rv & m)
  endtask
  task settle;
    repeat (8) @(posedge aclk);
  endtask
  task t_reset;
    `CHK("irq", 1'b0, irq)
    `CHK("pullups", 8'hFF, sink_port_pullup_en)
    `CHK("gp pullup", 4'hF, gp_pullup_en)
    rchk(8'h0C, 32'h7FF, 32'h0, "mask");
  endtask
  task t_timer;
    logic [31:0] h;
    wr(8'h0C, 32'h3);
    repeat (1100) @(posedge aclk);
    rchk(8'h08, 32'h3, 32'h3, "taps");
    `CHK("irq taps", 1'b1, irq)
    rd(8'h00);
    rd(8'h04);
    h = rv & 32'hF;
    // Long enough for the live upper nibble to move on
    repeat (600) @(posedge aclk);
    rchk(8'h04, 32'hF, h, "held upper");
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h3);
    `CHK("irq masked", 1'b0, irq)
    `CHK("no vector", 4'hF, irq_vector)
  endtask
  task t_gpio;
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h08);
    wr(8'h1C, 32'h01);
    wr(8'h0C, 32'h200);
    wr(8'h08, 32'h7FF);
    gp_pins_in <= 32'h10;
    settle();
    rchk(8'h08, 32'h200, 32'h0, "gp masked pin");
    gp_pins_in <= 32'h18;
    settle();
    rchk(8'h08, 32'h200, 32'h200, "gp rise");
    `CHK("gp vector", 4'h9, irq_vector)
    wr(8'h08, 32'h200);
    gp_pins_in <= 32'h100;
    settle();
    rchk(8'h08, 32'h200, 32'h0, "gp wrong edge");
    gp_pins_in <= 32'h0;
    settle();
    rchk(8'h08, 32'h200, 32'h200, "gp fall");
  endtask
  task t_sink;
    wr(8'h28, 32'h0F);
    `CHK("sink en", 8'hF0, sink_port_sink_en)
    `CHK("sink pullup", 8'h0F, sink_port_pullup_en)
    wr(8'h2C, 32'h03);
    wr(8'h30, 32'h02);
    wr(8'h0C, 32'h100);
    wr(8'h08, 32'h7FF);
    pull_low <= 8'h01;
    settle();
    rchk(8'h08, 32'h100, 32'h100, "sink fall");
    wr(8'h08, 32'h100);
    pull_low <= 8'h06;
    settle();
    rchk(8'h08, 32'h100, 32'h0, "sink no edge");
    pull_low <= 8'h04;
    settle();
    rchk(8'h08, 32'h100, 32'h100, "sink rise");
    rchk(8'h28, 32'hFF, 32'h0B, "sink pins");
    wr(8'h44, 32'hA);
    wr(8'h5C, 32'h5);
    `CHK("isink", 8'h5A, {sink_port_isink[31:28], sink_port_isink[7:4]})
  endtask
  task t_usb;
    wr(8'h0C, 32'h4FC);
    for (int j = 0; j < 7; j++)
    begin
      wr(8'h08, 32'h7FF);
      usb_ep_event <= (j < 5) ? 5'(1 << j) : 5'h00;
      usb_hub_event <= (j == 5);
      serial_event <= (j == 6);
      @(posedge aclk);
      usb_ep_event <= 5'h00;
      usb_hub_event <= 1'b0;
      serial_event <= 1'b0;
      rchk(8'h08, 32'h4FC, (j < 5) ? (32'h4 << j) : ((j == 5) ? 32'h80 : 32'h400), "event");
    end
  endtask
  task t_drive;
    // Port 0 pull-up rising, 1 open-drain, 2 and 3 push-pull
    wr(8'h14, 32'h911);
    `CHK("write resp", 2'b00, br)
    wr(8'h64, 32'hA5);
    wr(8'h68, 32'h3C);
    wr(8'h6C, 32'hFF);
    `CHK("gp modes", 4'h1, gp_pullup_en)
    `CHK("pull-up port", 16'h0000, gp_drive[0])
    `CHK("open drain", 16'hA55A, gp_drive[1])
    `CHK("push pull", 16'h3CFF, gp_drive[2])
    `CHK("narrow port", 16'h7F7F, gp_drive[3])
    wr(8'h34, 32'h1);
    `CHK("unmapped write", 2'b10, br)
    wr(8'h45, 32'hF);
    `CHK("misaligned resp", 2'b10, br)
    `CHK("misaligned kept", 4'hA, sink_port_isink[7:4])
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_timer();
    t_gpio();
    t_sink();
    t_usb();
    t_drive();
    rd(8'h38);
    `CHK("unmapped", 2'b10, rr)
    wrap_up();
  end
endmodule
bind vitpe_top vitpe_asserts u_vitpe_asserts (.*);
`default_nettype wire
